// [logic/divide_loop_adjust_pkg.sv]
// Constants, op codes and flag layout shared by the divide, loop and adjust block.
// Assumes one core clock and a decoder that presents one op at a time.
// ====================================================================
// Notes on behaviour
// - signed 16/16 divide: one word, 18 cycles, NZCV
// - signed 32/16 divide: one word, 18 cycles, NZCV
// - unsigned 16/16 divide: one word, 18 cycles, NZCV
// - unsigned 32/16 divide: one word, 18 cycles, NZCV
// - fractional divide: 18 cycles, NZCV, larger variants
// - holdoff blocks interrupts lit14 cycles, no flags
// - literal loop: end PC+offset, lit+1 passes
// - register loop: count register plus one passes
// - decimal adjust in place, one cycle, carry only
package divide_loop_adjust_pkg;
  // ====================================================================
  // Op codes from the decoder
  typedef enum logic [3:0] {
    signed_quotient_op        = 4'h0,
    signed_long_quotient_op   = 4'h1,
    unsigned_quotient_op      = 4'h2,
    unsigned_long_quotient_op = 4'h3,
    fractional_quotient_op    = 4'h4,
    interrupt_holdoff_op      = 4'h5,
    hardware_loop_op          = 4'h6,
    hardware_loop_reg_op      = 4'h7,
    bcd_adjust_op             = 4'h8
  } op_t;

  // ====================================================================
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOOP = 3'h2,
    ST_DIV  = 3'h4
  } seq_state_t;

  // ====================================================================
  // Status flag positions within the 4-bit flag word
  localparam int FLAG_C  = 0;
  localparam int FLAG_Z  = 1;
  localparam int FLAG_OV = 2;
  localparam int FLAG_N  = 3;
  localparam logic [3:0] FLAGS_DIV   = 4'hf;
  localparam logic [3:0] FLAGS_CARRY = 4'h1;
  localparam logic [3:0] FLAGS_NONE  = 4'h0;

  // ====================================================================
  // Timing and widths
  localparam int DIV_CYCLES  = 18;
  localparam int LOOP_CYCLES = 2;
  localparam int DIV_STEPS   = 16;
  localparam int HOLDOFF_W   = 14;
  localparam int LOOP_LIT_W  = 15;
  localparam int PC_W        = 24;

  // Decimal adjust correction terms
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [7:0] BCD_LO_FIX    = 8'h06;
  localparam logic [8:0] BCD_HI_FIX    = 9'h060;
endpackage

// [logic/div_if.sv]
// Carrier between the op sequencer and the iterative divider.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic        start;
  logic        is_signed;
  logic        is_long;
  logic        is_frac;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        done;
  logic [15:0] quotient;
  logic [15:0] remainder;
  logic [3:0]  flags;

  modport ctrl (output start, is_signed, is_long, is_frac, dividend, divisor,
                input done, quotient, remainder, flags);
  modport unit (input start, is_signed, is_long, is_frac, dividend, divisor,
                output done, quotient, remainder, flags);
endinterface
`default_nettype wire

// [logic/quotient_unit.sv]
// Restoring divider: 16 quotient bits, one per cycle, sign fix folded into the last step.
// Assumes start is a one-cycle pulse and is not raised while busy.
`timescale 1ns/1ps
`default_nettype none
module quotient_unit
  import divide_loop_adjust_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  div_if.unit       dv
);
  // ====================================================================
  // Operand magnitudes
  wire        a_neg = dv.is_signed & (dv.is_long ? dv.dividend[31] : dv.dividend[15]);
  wire [31:0] a_ext = dv.is_long ? dv.dividend : {{16{dv.is_signed & dv.dividend[15]}}, dv.dividend[15:0]};
  wire [31:0] a_abs = a_neg ? (32'h0 - a_ext) : a_ext;
  // Fractional form: dividend sits one word up, so the quotient is a fraction
  wire [31:0] a_mag = dv.is_frac ? {a_abs[15:0], 16'h0} : a_abs;
  wire        b_neg = dv.is_signed & dv.divisor[15];
  wire [15:0] b_mag = b_neg ? (16'h0 - dv.divisor) : dv.divisor;

  logic [16:0] rem_reg;
  logic [31:0] dvd_reg;
  logic [15:0] bmag_reg;
  logic [4:0]  cnt_reg;
  logic        run_reg;
  logic        qneg_reg;
  logic        aneg_reg;
  logic        sgn_reg;
  logic        pre_ov_reg;
  logic        done_reg;
  logic [15:0] q_reg;
  logic [15:0] r_reg;
  logic [3:0]  f_reg;

  // ====================================================================
  // One restoring step
  wire [16:0] trial = {rem_reg[15:0], dvd_reg[31]};
  wire        ge    = trial >= {1'b0, bmag_reg};
  wire [16:0] rem_next = ge ? (trial - {1'b0, bmag_reg}) : trial;
  wire        last_step = run_reg && cnt_reg == 5'(DIV_STEPS - 1);

  // Final signs from the last step's next values, so the fix costs no extra cycle
  // and the whole divide fits its cycle budget; a signed quotient past the signed range is overflow
  wire [15:0] q_mag   = {dvd_reg[14:0], ge};
  wire [15:0] q_fin   = qneg_reg ? (16'h0 - q_mag) : q_mag;
  wire [15:0] r_fin   = aneg_reg ? (16'h0 - rem_next[15:0]) : rem_next[15:0];
  wire        sgn_ov  = sgn_reg & (qneg_reg ? (q_mag > 16'h8000) : q_mag[15]);
  wire [3:0]  f_fin;
  assign f_fin[FLAG_N]  = q_fin[15];
  assign f_fin[FLAG_Z]  = q_fin == 16'h0;
  assign f_fin[FLAG_C]  = r_fin != 16'h0;
  assign f_fin[FLAG_OV] = pre_ov_reg | sgn_ov;

  // Control: load, then 16 steps, the last one also capturing the results
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      run_reg  <= 1'b0;
      cnt_reg  <= 5'h0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= last_step;
      if (dv.start)
      begin
        run_reg <= 1'b1;
        cnt_reg <= 5'h0;
      end
      else if (last_step)
        run_reg <= 1'b0;
      else if (run_reg)
        cnt_reg <= cnt_reg + 5'h1;
    end
  end

  // Datapath; high half not below divisor means quotient cannot fit
  always_ff @(posedge clk)
  begin
    if (dv.start)
    begin
      rem_reg    <= {1'b0, a_mag[31:16]};
      dvd_reg    <= {a_mag[15:0], 16'h0};
      bmag_reg   <= b_mag;
      qneg_reg   <= a_neg ^ b_neg;
      aneg_reg   <= a_neg;
      sgn_reg    <= dv.is_signed;
      pre_ov_reg <= a_mag[31:16] >= b_mag;
    end
    else if (run_reg)
    begin
      rem_reg <= rem_next;
      dvd_reg <= {dvd_reg[30:0], ge};
    end
    if (last_step)
    begin
      q_reg <= q_fin;
      r_reg <= r_fin;
      f_reg <= f_fin;
    end
  end

  assign dv.done      = done_reg;
  assign dv.quotient  = q_reg;
  assign dv.remainder = r_reg;
  assign dv.flags     = f_reg;
endmodule
`default_nettype wire

// [logic/divide_loop_adjust_ops.sv]
// Sequencer for divides, interrupt holdoff, loop setup and decimal adjust.
// Assumes the decoder holds op fields while op_valid and op_ready are high.
`timescale 1ns/1ps
`default_nettype none
module divide_loop_adjust_ops
  import divide_loop_adjust_pkg::*;
#(
  parameter bit HAS_FRACTIONAL = 1'b1
)(
  input  wire logic                                   clk,
  input  wire logic                                   reset,
  input  wire logic                                   op_valid,
  output logic                                        op_ready,
  input  wire divide_loop_adjust_pkg::op_t            op_code,
  input  wire logic [31:0]                            operand_a,
  input  wire logic [15:0]                            operand_b,
  input  wire logic [divide_loop_adjust_pkg::LOOP_LIT_W-1:0] op_literal,
  input  wire logic [divide_loop_adjust_pkg::PC_W-1:0]       pc,
  input  wire logic [divide_loop_adjust_pkg::PC_W-1:0]       loop_offset,
  input  wire logic                                   carry_in,
  input  wire logic                                   digit_carry_in,
  output logic                                        op_done,
  output logic [15:0]                                 result,
  output logic [15:0]                                 remainder,
  output logic [3:0]                                  flags,
  output logic [3:0]                                  flags_write,
  output logic                                        int_block,
  output logic                                        loop_load,
  output logic [divide_loop_adjust_pkg::PC_W-1:0]     loop_end_addr,
  output logic [16:0]                                 loop_count
);
  div_if dvi ();

  quotient_unit u_div (
    .clk   (clk),
    .reset (reset),
    .dv    (dvi.unit)
  );

  // ====================================================================
  // Decode
  seq_state_t state_reg;
  seq_state_t state_next;
  wire accept   = op_valid && op_ready;
  wire is_div   = op_code inside {signed_quotient_op, signed_long_quotient_op, unsigned_quotient_op,
                                  unsigned_long_quotient_op}
                  || (op_code == fractional_quotient_op && HAS_FRACTIONAL);
  wire is_loop  = op_code == hardware_loop_op || op_code == hardware_loop_reg_op;
  assign op_ready = state_reg == ST_IDLE;

  // Divider launch
  assign dvi.start     = accept && is_div;
  assign dvi.is_signed = op_code == signed_quotient_op || op_code == signed_long_quotient_op
                         || op_code == fractional_quotient_op;
  assign dvi.is_long   = op_code == signed_long_quotient_op || op_code == unsigned_long_quotient_op;
  assign dvi.is_frac   = op_code == fractional_quotient_op;
  assign dvi.dividend  = operand_a;
  assign dvi.divisor   = operand_b;

  // Decimal adjust of the low byte, carry sticks once set
  wire       lo_fix  = operand_a[3:0] > BCD_MAX_DIGIT || digit_carry_in;
  wire [8:0] lo_sum  = {1'b0, operand_a[7:0]} + (lo_fix ? {1'b0, BCD_LO_FIX} : 9'h0);
  wire       hi_fix  = lo_sum[8] || lo_sum[7:4] > BCD_MAX_DIGIT || carry_in;
  wire [8:0] bcd_sum = {1'b0, lo_sum[7:0]} + (hi_fix ? BCD_HI_FIX : 9'h0);
  wire       bcd_c   = carry_in | lo_sum[8] | bcd_sum[8];

  // Loop count: value plus one passes
  wire [15:0] loop_src = op_code == hardware_loop_reg_op ? operand_a[15:0] : {1'b0, op_literal};

  // ====================================================================
  // Sequencer: loop takes one extra cycle, divide waits for the unit
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (accept && is_div) state_next = ST_DIV;
               else if (accept && is_loop) state_next = ST_LOOP;
      ST_LOOP: state_next = ST_IDLE;
      ST_DIV:  if (dvi.done) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ====================================================================
  // Interrupt holdoff counter; blocked while non-zero
  logic [HOLDOFF_W-1:0] hold_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
      hold_reg <= '0;
    else if (accept && op_code == interrupt_holdoff_op)
      hold_reg <= op_literal[HOLDOFF_W-1:0];
    else if (hold_reg != '0)
      hold_reg <= hold_reg - 1'b1;
  end
  assign int_block = hold_reg != '0;

  // ====================================================================
  // Completion and results; single-cycle ops finish the cycle after accept
  logic            loop_pend_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op_done       <= 1'b0;
      flags_write   <= FLAGS_NONE;
      loop_load     <= 1'b0;
      loop_pend_reg <= 1'b0;
      result        <= 16'h0;
      remainder     <= 16'h0;
      flags         <= 4'h0;
      loop_end_addr <= '0;
      loop_count    <= 17'h0;
    end
    else
    begin
      op_done       <= 1'b0;
      flags_write   <= FLAGS_NONE;
      loop_load     <= 1'b0;
      loop_pend_reg <= accept && is_loop;
      if (accept && is_loop)
      begin
        loop_end_addr <= pc + loop_offset;
        loop_count    <= {1'b0, loop_src} + 17'h1;
      end
      if (loop_pend_reg)
      begin
        op_done   <= 1'b1;
        loop_load <= 1'b1;
      end
      else if (dvi.done)
      begin
        op_done     <= 1'b1;
        result      <= dvi.quotient;
        remainder   <= dvi.remainder;
        flags       <= dvi.flags;
        flags_write <= FLAGS_DIV;
      end
      else if (accept && op_code == bcd_adjust_op)
      begin
        op_done            <= 1'b1;
        result             <= {operand_a[15:8], bcd_sum[7:0]};
        flags              <= 4'h0;
        flags[FLAG_C]      <= bcd_c;
        flags_write        <= FLAGS_CARRY;
      end
      else if (accept && !is_div && !is_loop)
        op_done <= 1'b1;
    end
  end

  // ====================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_div_signed_time:   assert property (accept && op_code == signed_quotient_op |-> ##18 op_done && flags_write == FLAGS_DIV) else $error("signed divide not 18 cycles");
  a_div_slong_time:    assert property (accept && op_code == signed_long_quotient_op |=> !op_done[*8] ##1 !op_done[*8] ##1 !op_done ##1 op_done) else $error("long signed divide early");
  a_div_slong_done:    assert property (accept && op_code == signed_long_quotient_op |-> ##18 op_done && flags_write == FLAGS_DIV) else $error("long signed divide late");
  a_div_unsigned_time: assert property (accept && op_code == unsigned_quotient_op |=> !op_ready[*8] ##1 !op_ready[*8] ##1 !op_ready ##1 op_ready && op_done) else $error("unsigned divide timing");
  a_div_ulong_time:    assert property (accept && op_code == unsigned_long_quotient_op |-> ##18 op_done && flags_write == FLAGS_DIV) else $error("long unsigned divide timing");
  a_div_frac_time:     assert property (accept && op_code == fractional_quotient_op && HAS_FRACTIONAL |-> ##18 op_done && flags_write == FLAGS_DIV) else $error("fractional divide timing");
  a_holdoff_load:      assert property (accept && op_code == interrupt_holdoff_op && op_literal[HOLDOFF_W-1:0] > 14'h1 |=> int_block && hold_reg == $past(op_literal[HOLDOFF_W-1:0]) && op_done && flags_write == FLAGS_NONE) else $error("holdoff load wrong");
  a_holdoff_count:     assert property (int_block && !(accept && op_code == interrupt_holdoff_op) |=> hold_reg == $past(hold_reg) - 1'b1) else $error("holdoff not counting");
  a_loop_lit_setup:    assert property (accept && op_code == hardware_loop_op |-> ##2 op_done && loop_load && loop_end_addr == $past(pc + loop_offset, 2) && loop_count == {2'h0, $past(op_literal, 2)} + 17'h1) else $error("literal loop setup wrong");
  a_loop_reg_setup:    assert property (accept && op_code == hardware_loop_reg_op |-> ##2 op_done && flags_write == FLAGS_NONE && loop_count == {1'b0, $past(operand_a[15:0], 2)} + 17'h1) else $error("register loop setup wrong");
  a_bcd_adjust_one:    assert property (accept && op_code == bcd_adjust_op && (!digit_carry_in || operand_a[3:0] <= BCD_MAX_DIGIT - BCD_LO_FIX[3:0]) |=> op_done && flags_write == FLAGS_CARRY && result[3:0] <= BCD_MAX_DIGIT) else $error("decimal adjust wrong");

  c_signed_divide: cover property (accept && op_code == signed_quotient_op ##18 op_done);
  c_holdoff_run:   cover property (accept && op_code == interrupt_holdoff_op ##1 int_block);
  c_loop_reg:      cover property (accept && op_code == hardware_loop_reg_op ##2 loop_load);
  c_bcd_carry:     cover property (accept && op_code == bcd_adjust_op ##1 flags[FLAG_C]);
endmodule
`default_nettype wire

// [test/divide_loop_adjust_ops_tb.sv]
// Self-checking bench for the divide, loop and adjust sequencer.
// Assumes the package is compiled first; inputs change on falling edges only.
`timescale 1ns/1ps
`default_nettype none
module divide_loop_adjust_ops_tb;
  import divide_loop_adjust_pkg::*;
  logic        clk, reset, op_valid, op_ready, carry_in, digit_carry_in;
  logic        op_done, int_block, loop_load;
  op_t         op_code;
  logic [31:0] operand_a;
  logic [15:0] operand_b, result, remainder, seed;
  logic [14:0] op_literal;
  logic [23:0] pc, loop_offset, loop_end_addr;
  logic [3:0]  flags, flags_write;
  logic [16:0] loop_count;
  int          n_errors = 0;
  int          comparisons = 0;
  // Corner divides: overflow, divide by zero, fit boundary, negative fraction
  int          c_op [6] = '{0, 2, 3, 3, 1, 4};
  logic [31:0] c_a [6] = '{32'h8000, 32'h1234, 32'h0005_0000, 32'h0004_ffff, 32'hffff_8000, 32'he000};
  logic [15:0] c_b [6] = '{16'hffff, 16'h0000, 16'h0005, 16'h0005, 16'hffff, 16'h4000};

  divide_loop_adjust_ops #(.HAS_FRACTIONAL(1'b1)) u_divide_loop_adjust_ops (
    .clk(clk), .reset(reset), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .operand_a(operand_a), .operand_b(operand_b), .op_literal(op_literal), .pc(pc),
    .loop_offset(loop_offset), .carry_in(carry_in), .digit_carry_in(digit_carry_in),
    .op_done(op_done), .result(result), .remainder(remainder), .flags(flags),
    .flags_write(flags_write), .int_block(int_block), .loop_load(loop_load),
    .loop_end_addr(loop_end_addr), .loop_count(loop_count)
  );

  // ====================================================================
  // Clock, compare and verdict
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Fibonacci shift register, taps 16 14 13 11
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // ====================================================================
  // Expected values
  task automatic exp_div(input int op, input logic [31:0] a, input logic [15:0] b,
                         output logic [15:0] q, output logic [15:0] r, output logic [3:0] f);
    longint dd, dv, qq, rr;
    bit     sg, ov;
    sg = (op == 0 || op == 1 || op == 4);
    case (op)
      0:       dd = longint'($signed(a[15:0]));
      1:       dd = longint'($signed(a));
      2:       dd = longint'(a[15:0]);
      3:       dd = longint'(a);
      default: dd = longint'($signed(a[15:0])) * 65536;
    endcase
    dv = sg ? longint'($signed(b)) : longint'(b);
    qq = (dv == 0) ? 0 : dd / dv;
    rr = (dv == 0) ? 0 : dd % dv;
    ov = (dv == 0) || (sg ? (qq > 32767 || qq < -32768) : (qq > 65535));
    q = qq[15:0];
    r = rr[15:0];
    f = {q[15], ov, q == 16'h0000, r != 16'h0000};
  endtask

  // Low byte corrected to packed decimal, carry kept if already set
  function automatic logic [16:0] exp_bcd(logic [15:0] a, logic c, logic dc);
    logic [8:0] t;
    t = {1'b0, a[7:0]};
    if (dc || t[3:0] > 4'h9)
      t = t + 9'h006;
    if (c || t[8] || t[7:4] > 4'h9)
      t = t + 9'h060;
    return {c | t[8], a[15:8], t[7:0]};
  endfunction

  // Offer one op and count edges until completion
  task automatic run(input op_t op, input logic [31:0] a, input logic [15:0] b,
                     input logic [14:0] lit, input int exp_n);
    int n;
    @(negedge clk);
    check("ready", op_ready, 32'h1);
    op_code = op;
    operand_a = a;
    operand_b = b;
    op_literal = lit;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    n = 1;
    while (op_done !== 1'b1 && n < 40)
    begin
      check("busy", op_ready, 32'h0);
      @(negedge clk);
      n++;
    end
    check("cycles", n, exp_n);
  endtask

  // ====================================================================
  // Main sequence
  initial
  begin
    int          i, k, cnt, op;
    logic [31:0] a;
    logic [15:0] b, q, r, x;
    logic [3:0]  f;
    logic [16:0] e;
    seed = 16'h000d;
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = bcd_adjust_op;
    operand_a = 32'h0;
    operand_b = 16'h0;
    op_literal = 15'h0;
    pc = 24'h0;
    loop_offset = 24'h0;
    carry_in = 1'b0;
    digit_carry_in = 1'b0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    check("rst", {op_ready, op_done, int_block, loop_load, flags, result}, {4'h8, 4'h0, 16'h0});
    // Divides: corners first, then random operands over all five kinds
    for (i = 0; i < 66; i++)
    begin
      x = rnd();
      op = (i < 6) ? c_op[i] : i % 5;
      a = (i < 6) ? c_a[i] : (x[0] ? {rnd(), rnd()} : {{16{x[15]}}, x});
      b = (i < 6) ? c_b[i] : rnd();
      exp_div(op, a, b, q, r, f);
      run(op_t'(op), a, b, 15'h0, DIV_CYCLES);
      check("dv_fw", flags_write, FLAGS_DIV);
      check("dv_ov", flags[FLAG_OV], f[FLAG_OV]);
      if (!f[FLAG_OV])
        check("dv_res", {result, remainder, flags}, {q, r, f});
    end
    // Holdoff: zero, widest count with spare top bit, random, then a reload
    for (i = 0; i < 6; i++)
    begin
      k = (i == 0) ? 0 : (i == 1) ? 16383 : (rnd() % 20) + 1;
      run(interrupt_holdoff_op, 32'h0, 16'h0, {1'b1, k[13:0]}, 1);
      check("ho_fw", flags_write, FLAGS_NONE);
      if (i == 5)
      begin
        k = 3;
        run(interrupt_holdoff_op, 32'h0, 16'h0, 15'h0003, 1);
      end
      cnt = 0;
      while (int_block === 1'b1 && cnt < 20000)
      begin
        cnt++;
        @(negedge clk);
      end
      check("ho_len", cnt, k);
    end
    // Loops: literal and register count, extreme counts and address wrap
    for (i = 0; i < 8; i++)
    begin
      pc = {rnd(), rnd()};
      loop_offset = (i == 0) ? 24'hffffff : {rnd(), rnd()};
      a = (i == 1) ? 32'h0000_ffff : {rnd(), rnd()};
      x = (i == 0) ? 16'h7fff : rnd();
      run(i[0] ? hardware_loop_reg_op : hardware_loop_op, a, 16'h0, x[14:0], LOOP_CYCLES);
      e = i[0] ? {1'b0, a[15:0]} + 17'h1 : {2'b0, x[14:0]} + 17'h1;
      check("lp_end", loop_end_addr, 24'(pc + loop_offset));
      check("lp_cnt", {loop_load, flags_write, loop_count}, {1'b1, 4'h0, e});
    end
    // Decimal adjust with random carries
    for (i = 0; i < 24; i++)
    begin
      x = rnd();
      carry_in = x[0];
      digit_carry_in = x[1];
      a = {16'h0, rnd()};
      e = exp_bcd(a[15:0], x[0], x[1]);
      run(bcd_adjust_op, a, 16'h0, 15'h0, 1);
      check("bcd", {result, flags[FLAG_C], flags_write}, {e[15:0], e[16], FLAGS_CARRY});
    end
    // Reset in mid divide leaves the sequencer idle
    @(negedge clk);
    op_code = signed_quotient_op;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    repeat (5) @(negedge clk);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    check("rst2", {op_ready, op_done}, 32'h2);
    run(unsigned_quotient_op, 32'h0000_0064, 16'h0007, 15'h0, DIV_CYCLES);
    check("dv_after", {result, remainder}, {16'd14, 16'd2});
    test_done();
  end

  // Watchdog well beyond the expected run of about 18000 cycles
  initial
  begin
    #(50 * 60000);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
